// >>> tile_status_map.vh
// register offsets, field positions and timing counts of the tile status bank
`ifndef TILE_STATUS_MAP_VH
`define TILE_STATUS_MAP_VH

// ----------------------------------------------------------------------
// register indexes
// ----------------------------------------------------------------------
`define TILE_BOOT_STATUS_IDX       8'h03
`define SECURITY_CONFIGURATION_IDX 8'h05
`define RING_OSCILLATOR_CONTROL_IDX 8'h06
`define CORE_CELL_OSC_COUNT_IDX    8'h07
`define CORE_WIRE_OSC_COUNT_IDX    8'h08
`define PERIPH_CELL_OSC_COUNT_IDX  8'h09
`define PERIPH_WIRE_OSC_COUNT_IDX  8'h0A
`define MEMORY_SIZE_IDX            8'h0C
`define DEBUG_STATUS_SNAPSHOT_IDX  8'h10

// ----------------------------------------------------------------------
// boot status fields
// ----------------------------------------------------------------------
`define BOOT_PROC_MSB        23
`define BOOT_PROC_LSB        16
`define BOOT_OVERRIDE_BIT    8
`define BOOT_CORE2_PWR_BIT   5
`define BOOT_SKIP_POLL_BIT   4
`define BOOT_FROM_RAM_BIT    3
`define BOOT_FROM_JTAG_BIT   2
`define BOOT_PLL_MSB         1

// ----------------------------------------------------------------------
// security configuration fields
// ----------------------------------------------------------------------
`define SEC_WRITE_LOCK_BIT   31
`define SEC_NO_GDEBUG_BIT    14
`define SEC_OTP_ALL_LOCK_BIT 12
`define SEC_SECTOR_MSB       11
`define SEC_SECTOR_LSB       8
`define SEC_REDUNDANCY_BIT   7
`define SEC_BOOT_OVR_BIT     5
`define SEC_NO_PLL_JTAG_BIT  4
`define SEC_NO_DBG_TAP_BIT   0
`define SEC_WRITABLE_MASK    32'h80005FB1

// ----------------------------------------------------------------------
// ring oscillator control and snapshot fields
// ----------------------------------------------------------------------
`define OSC_CORE_RUN_BIT     1
`define OSC_PERIPH_RUN_BIT   0
`define OSC_CTRL_RESET       2'h0
`define OSC_COUNT_W          16
`define SNAP_WIDTH           11
`define SNAP_DI_BIT          8
`define SNAP_WRITABLE_MASK   11'h6FF
`define MEM_SIZE_LOW_MASK    32'hFFFFFFFC

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define OSC_SETTLE_CYCLES    10

`endif

// >>> ring_osc_counter.v
// count register clocked by one external ring oscillator, advancing on its rising edges while run_in is high
`timescale 1ns/1ps

module ring_osc_counter #(
   parameter CW = 16
) (
   // oscillator clock and control
   input  wire          osc_clk_in,
   input  wire          run_in,
   // count
   output reg  [CW-1:0] count_out
);

   // count kept without any reset so it survives a system reset
   initial count_out = {CW{1'b0}};

   // counts oscillator edges while enabled
   always @(posedge osc_clk_in) begin
      if (run_in) begin
         count_out <= count_out + {{(CW-1){1'b0}}, 1'b1};
      end
   end

endmodule

// >>> tile_status_config_regs.v
// processor status register bank: boot status, security, oscillators, debug snapshot
`timescale 1ns/1ps
`include "tile_status_map.vh"

// Operation
// - boot status read-only, processor number bits 23:16
// - bits 3,2 boot source, 1:0 PLL straps
// - bit 8 override, 5 core power, 4 poll
// - security word copied from one-time memory
// - bit 31 set locks further security writes
// - bits 14, 0, 4 disable debug paths
// - bit 12 all-sector lock, 11:8, 7 redundancy
// - bit 5 forces boot from one-time memory
// - four ring oscillators each clocking a counter
// - control bit 1 core, bit 0 peripheral
// - four count registers, bits 15:0, ordered
// - oscillator counts survive system reset
// - oscillators asynchronous to the tile clock
// - memory size bits 31:2, low bits zero
// - snapshot captures thread status on debug entry
// - snapshot bit 0 events, bit 1 interrupts
// - bits 2,3,4 enabling, handler, kernel
// - bit 7 fast, 6 paused, 10 address space
// - bit 8 read-only, bit 9 writable
module tile_status_config_regs #(
   parameter [7:0]  PROCESSOR_NUMBER = 8'h00,
   parameter [31:0] MEMORY_BYTES     = 32'h00040000,
   parameter        CW               = `OSC_COUNT_W
) (
   // clock and reset
   input  wire        clk_sys_in,
   input  wire        rst_in,
   // status register access port
   input  wire [7:0]  reg_index_in,
   input  wire        reg_write_in,
   input  wire [31:0] reg_wdata_in,
   input  wire        reg_read_in,
   output reg  [31:0] reg_rdata_out,
   // boot state inputs
   input  wire [1:0]  pll_strap_value_in,
   input  wire        boot_from_ram_in,
   input  wire        boot_from_jtag_in,
   input  wire        skip_otp_poll_in,
   input  wire        second_core_powered_in,
   // one-time memory load
   input  wire        otp_load_in,
   input  wire [31:0] otp_security_word_in,
   // thread status and debugger entry
   input  wire        debug_entry_in,
   input  wire [10:0] thread_status_in,
   // ring oscillator clocks
   input  wire        core_cell_osc_clk_in,
   input  wire        core_wire_osc_clk_in,
   input  wire        periph_cell_osc_clk_in,
   input  wire        periph_wire_osc_clk_in,
   // security controls
   output wire        global_debug_off_out,
   output wire        debug_tap_off_out,
   output wire        pll_jtag_off_out,
   output wire        otp_all_locked_out,
   output wire [3:0]  otp_sector_locked_out,
   output wire        otp_redundancy_on_out,
   output wire        otp_boot_override_out,
   output wire        boot_from_otp_out,
   // oscillator run levels
   output wire        core_osc_run_out,
   output wire        periph_osc_run_out
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   reg  [31:0]             security_reg;
   reg  [1:0]              osc_ctrl_reg;
   reg  [`SNAP_WIDTH-1:0]  snapshot_reg;
   reg  [31:0]             boot_status_reg;
   reg  [31:0]             rdata_next;
   wire [CW-1:0]           osc_count [0:3];
   wire [3:0]              osc_clk;
   wire [3:0]              osc_run;

   // write qualifies with the index
   function wr_hit;
      input [7:0] idx;
      begin
         wr_hit = reg_write_in && (reg_index_in == idx);
      end
   endfunction

   // ----------------------------------------------------------------------
   // boot status, sampled every cycle from the boot logic
   // ----------------------------------------------------------------------
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         boot_status_reg <= 32'h00000000;
      end else begin
         boot_status_reg <= 32'h00000000;
         boot_status_reg[`BOOT_PROC_MSB:`BOOT_PROC_LSB] <= PROCESSOR_NUMBER;
         boot_status_reg[`BOOT_OVERRIDE_BIT] <= security_reg[`SEC_BOOT_OVR_BIT];
         boot_status_reg[`BOOT_CORE2_PWR_BIT] <= second_core_powered_in;
         boot_status_reg[`BOOT_SKIP_POLL_BIT] <= skip_otp_poll_in;
         boot_status_reg[`BOOT_FROM_RAM_BIT] <= boot_from_ram_in;
         boot_status_reg[`BOOT_FROM_JTAG_BIT] <= boot_from_jtag_in;
         boot_status_reg[`BOOT_PLL_MSB:0] <= pll_strap_value_in;
      end
   end

   // ----------------------------------------------------------------------
   // security word: loaded from one-time memory, self-locking
   // ----------------------------------------------------------------------
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         security_reg <= 32'h00000000;
      end else if (otp_load_in) begin
         security_reg <= otp_security_word_in & `SEC_WRITABLE_MASK;
      end else if (wr_hit(`SECURITY_CONFIGURATION_IDX) &&
                   !security_reg[`SEC_WRITE_LOCK_BIT]) begin
         security_reg <= reg_wdata_in & `SEC_WRITABLE_MASK;
      end
   end

   // security fields driven to the guarded logic
   assign global_debug_off_out  = security_reg[`SEC_NO_GDEBUG_BIT];
   assign debug_tap_off_out     = security_reg[`SEC_NO_DBG_TAP_BIT];
   assign pll_jtag_off_out      = security_reg[`SEC_NO_PLL_JTAG_BIT];
   assign otp_all_locked_out    = security_reg[`SEC_OTP_ALL_LOCK_BIT];
   assign otp_sector_locked_out = security_reg[`SEC_SECTOR_MSB:`SEC_SECTOR_LSB] |
                                  {4{security_reg[`SEC_OTP_ALL_LOCK_BIT]}};
   assign otp_redundancy_on_out = security_reg[`SEC_REDUNDANCY_BIT];
   assign otp_boot_override_out = security_reg[`SEC_BOOT_OVR_BIT];
   // override beats the pin-selected boot source
   assign boot_from_otp_out     = security_reg[`SEC_BOOT_OVR_BIT];

   // ----------------------------------------------------------------------
   // ring oscillator control
   // ----------------------------------------------------------------------
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         osc_ctrl_reg <= `OSC_CTRL_RESET;
      end else if (wr_hit(`RING_OSCILLATOR_CONTROL_IDX)) begin
         osc_ctrl_reg <= reg_wdata_in[1:0];
      end
   end

   assign core_osc_run_out   = osc_ctrl_reg[`OSC_CORE_RUN_BIT];
   assign periph_osc_run_out = osc_ctrl_reg[`OSC_PERIPH_RUN_BIT];

   // ----------------------------------------------------------------------
   // four oscillator counters on their own asynchronous clocks
   // ----------------------------------------------------------------------
   assign osc_clk = {periph_wire_osc_clk_in, periph_cell_osc_clk_in,
                     core_wire_osc_clk_in, core_cell_osc_clk_in};
   assign osc_run = {periph_osc_run_out, periph_osc_run_out,
                     core_osc_run_out, core_osc_run_out};

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : osc_bank
         // counts read only after a stop, so no crossing is needed
         ring_osc_counter #(
            .CW (CW)
         ) u_counter (
            .osc_clk_in (osc_clk[g]),
            .run_in     (osc_run[g]),
            .count_out  (osc_count[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // debug status snapshot
   // ----------------------------------------------------------------------
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         snapshot_reg <= {`SNAP_WIDTH{1'b0}};
      end else if (debug_entry_in) begin
         snapshot_reg <= thread_status_in;
      end else if (wr_hit(`DEBUG_STATUS_SNAPSHOT_IDX)) begin
         // dual-issue bit stays, the rest takes the debugger's value
         snapshot_reg <= (reg_wdata_in[`SNAP_WIDTH-1:0] & `SNAP_WRITABLE_MASK) |
                         (snapshot_reg & ~`SNAP_WRITABLE_MASK);
      end
   end

   // ----------------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------------
   always @* begin
      rdata_next = 32'h00000000;
      case (reg_index_in)
         `TILE_BOOT_STATUS_IDX:        rdata_next = boot_status_reg;
         `SECURITY_CONFIGURATION_IDX:  rdata_next = security_reg;
         `RING_OSCILLATOR_CONTROL_IDX: rdata_next = {30'h0, osc_ctrl_reg};
         `CORE_CELL_OSC_COUNT_IDX:     rdata_next = {16'h0, osc_count[0]};
         `CORE_WIRE_OSC_COUNT_IDX:     rdata_next = {16'h0, osc_count[1]};
         `PERIPH_CELL_OSC_COUNT_IDX:   rdata_next = {16'h0, osc_count[2]};
         `PERIPH_WIRE_OSC_COUNT_IDX:   rdata_next = {16'h0, osc_count[3]};
         `MEMORY_SIZE_IDX:             rdata_next = MEMORY_BYTES & `MEM_SIZE_LOW_MASK;
         `DEBUG_STATUS_SNAPSHOT_IDX:   rdata_next = {21'h0, snapshot_reg};
         default:                      rdata_next = 32'h00000000;
      endcase
   end

   // read data registered one cycle after the request
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= 32'h00000000;
      end else if (reg_read_in) begin
         reg_rdata_out <= rdata_next;
      end
   end

endmodule

// >>> tile_status_monitor.sv
// assertion checker for the tile status register bank
`timescale 1ns/1ps

module tile_status_monitor #(
   parameter [31:0] MEMORY_BYTES = 32'h00040000
) (
   // clock, reset and access port
   input wire        clk_sys_in,
   input wire        rst_in,
   input wire [7:0]  reg_index_in,
   input wire        reg_write_in,
   input wire [31:0] reg_wdata_in,
   input wire        reg_read_in,
   input wire [31:0] reg_rdata_out,
   // loads and captures
   input wire        otp_load_in,
   input wire [31:0] otp_security_word_in,
   input wire        debug_entry_in,
   input wire [10:0] thread_status_in,
   // levels driven by the bank
   input wire        global_debug_off_out,
   input wire        debug_tap_off_out,
   input wire        pll_jtag_off_out,
   input wire        otp_all_locked_out,
   input wire [3:0]  otp_sector_locked_out,
   input wire        otp_redundancy_on_out,
   input wire        boot_from_otp_out,
   input wire        core_osc_run_out,
   input wire        periph_osc_run_out
);
   reg        lock_reg;
   wire [1:0] run_v = {core_osc_run_out, periph_osc_run_out};
   wire [1:0] wlo_v = reg_wdata_in[1:0];
   wire [3:0] wsc_v = reg_wdata_in[11:8];
   wire [3:0] osc_v = otp_security_word_in[11:8];
   wire [5:0] sec_v = {global_debug_off_out, otp_all_locked_out, otp_redundancy_on_out,
                       boot_from_otp_out, pll_jtag_off_out, debug_tap_off_out};
   wire [5:0] wv = {reg_wdata_in[14], reg_wdata_in[12], reg_wdata_in[7],
                    reg_wdata_in[5], reg_wdata_in[4], reg_wdata_in[0]};
   wire [5:0] ov = {otp_security_word_in[14], otp_security_word_in[12],
                    otp_security_word_in[7], otp_security_word_in[5],
                    otp_security_word_in[4], otp_security_word_in[0]};

   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   // tracks the self-lock bit of the security word
   always @(posedge clk_sys_in or posedge rst_in)
      if (rst_in) lock_reg <= 1'b0;
      else if (otp_load_in) lock_reg <= otp_security_word_in[31];
      else if (reg_write_in && reg_index_in == 8'h05 && !lock_reg) lock_reg <= reg_wdata_in[31];

   // ----------------------------------------------------------------------
   // access steps
   // ----------------------------------------------------------------------
   sequence s_rd(logic [7:0] i);
      reg_read_in && reg_index_in == i;
   endsequence
   sequence s_wr(logic [7:0] i);
      reg_write_in && reg_index_in == i && !otp_load_in;
   endsequence

   property p_ctrl_set;
      s_wr(8'h06) |=> run_v == $past(wlo_v);
   endproperty
   property p_ctrl_read;
      s_rd(8'h06) |=> reg_rdata_out == {30'h0, $past(run_v)};
   endproperty
   property p_sec_set;
      s_wr(8'h05) ##0 !lock_reg |=> sec_v == $past(wv)
         && otp_sector_locked_out == ($past(wsc_v) | {4{otp_all_locked_out}});
   endproperty
   property p_sec_lock;
      s_wr(8'h05) ##0 lock_reg |=> $stable(sec_v) && $stable(otp_sector_locked_out);
   endproperty
   property p_otp_load;
      otp_load_in |=> sec_v == $past(ov)
         && otp_sector_locked_out == ($past(osc_v) | {4{otp_all_locked_out}});
   endproperty
   property p_unmapped;
      reg_read_in && !(reg_index_in inside {8'h03, 8'h05, [8'h06:8'h0A], 8'h0C, 8'h10})
         |=> reg_rdata_out == 32'h0;
   endproperty
   property p_mem;
      s_rd(8'h0C) |=> reg_rdata_out == (MEMORY_BYTES & 32'hFFFFFFFC);
   endproperty
   property p_snap;
      debug_entry_in ##1 s_rd(8'h10) |=> reg_rdata_out == {21'h0, $past(thread_status_in, 2)};
   endproperty

   a_ctrl_set:  assert property (p_ctrl_set)  else $error("run levels miss write");
   a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
   a_sec_set:   assert property (p_sec_set)   else $error("security levels miss write");
   a_sec_lock:  assert property (p_sec_lock)  else $error("locked security changed");
   a_otp_load:  assert property (p_otp_load)  else $error("security load wrong");
   a_unmapped:  assert property (p_unmapped)  else $error("unmapped read not zero");
   a_mem:       assert property (p_mem)       else $error("memory size wrong");
   a_snap:      assert property (p_snap)      else $error("snapshot capture wrong");
endmodule

bind tile_status_config_regs tile_status_monitor #(.MEMORY_BYTES(MEMORY_BYTES))
   tile_status_monitor_i (
   .clk_sys_in, .rst_in, .reg_index_in, .reg_write_in, .reg_wdata_in, .reg_read_in,
   .reg_rdata_out, .otp_load_in, .otp_security_word_in, .debug_entry_in,
   .thread_status_in, .global_debug_off_out, .debug_tap_off_out, .pll_jtag_off_out,
   .otp_all_locked_out, .otp_sector_locked_out, .otp_redundancy_on_out,
   .boot_from_otp_out, .core_osc_run_out, .periph_osc_run_out);

// >>> tile_status_config_regs_bench.sv
// self-checking bench for the tile status register bank
`timescale 1ns/1ps

module tile_status_config_regs_bench;
   reg         clk_sys_in = 1'b0;
   reg         rst_in = 1'b1;
   reg  [7:0]  idx = 8'h00;
   reg         wr = 1'b0;
   reg         rs = 1'b0;
   reg  [31:0] wd = 32'h0;
   reg         ld = 1'b0;
   reg  [31:0] ow = 32'h0;
   reg         dbg = 1'b0;
   reg  [10:0] thr = 11'h0;
   reg  [3:0]  oc = 4'h0;
   // boot levels: second core, skip poll, from ram, from jtag, pll straps
   reg  [5:0]  bt = 6'h3A;
   reg  [31:0] v, k;
   reg  [31:0] c0 [0:3];
   wire [31:0] rdat;
   wire [3:0]  sect;
   wire        gdo, tap, pjo, all, red, ovr, bfo, crun, prun;
   integer     err_count = 0;
   integer     checked = 0;

   always #4 clk_sys_in = ~clk_sys_in;
   // four free-running oscillators, unrelated to the tile clock
   always #2.6 oc[0] = ~oc[0];
   always #3.3 oc[1] = ~oc[1];
   always #4.1 oc[2] = ~oc[2];
   always #5.7 oc[3] = ~oc[3];

   tile_status_config_regs #(.PROCESSOR_NUMBER(8'h5A), .MEMORY_BYTES(32'h00040007))
   tile_status_config_regs_i (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_index_in(idx), .reg_write_in(wr),
      .reg_wdata_in(wd), .reg_read_in(rs), .reg_rdata_out(rdat),
      .pll_strap_value_in(bt[1:0]), .boot_from_ram_in(bt[3]), .boot_from_jtag_in(bt[2]),
      .skip_otp_poll_in(bt[4]), .second_core_powered_in(bt[5]), .otp_load_in(ld),
      .otp_security_word_in(ow), .debug_entry_in(dbg), .thread_status_in(thr),
      .core_cell_osc_clk_in(oc[0]), .core_wire_osc_clk_in(oc[1]),
      .periph_cell_osc_clk_in(oc[2]), .periph_wire_osc_clk_in(oc[3]),
      .global_debug_off_out(gdo), .debug_tap_off_out(tap), .pll_jtag_off_out(pjo),
      .otp_all_locked_out(all), .otp_sector_locked_out(sect), .otp_redundancy_on_out(red),
      .otp_boot_override_out(ovr), .boot_from_otp_out(bfo), .core_osc_run_out(crun),
      .periph_osc_run_out(prun));

   // ----------------------------------------------------------------------
   // access tasks and comparison
   // ----------------------------------------------------------------------
   task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("unexpected %0s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wrt(input [7:0] i, input [31:0] d);
      begin
         @(posedge clk_sys_in);
         idx <= i;
         wd <= d;
         wr <= 1'b1;
         @(posedge clk_sys_in);
         wr <= 1'b0;
         #1;
      end
   endtask
   task rd(input [7:0] i, output [31:0] q);
      begin
         @(posedge clk_sys_in);
         dbg <= 1'b0;
         idx <= i;
         rs <= 1'b1;
         @(posedge clk_sys_in);
         rs <= 1'b0;
         #1 q = rdat;
      end
   endtask
   task ckr(input [7:0] i, input [31:0] e);
      begin
         rd(i, v);
         chk("rdata", v, e);
      end
   endtask
   task otp(input [31:0] w);
      begin
         @(posedge clk_sys_in);
         ld <= 1'b1;
         ow <= w;
         @(posedge clk_sys_in);
         ld <= 1'b0;
         #1;
      end
   endtask
   task snap(input [10:0] t);
      begin
         @(posedge clk_sys_in);
         thr <= t;
         dbg <= 1'b1;
      end
   endtask
   task osc_round(input [31:0] run, input [31:0] same);
      begin
         wrt(8'h06, run);
         repeat (200) @(posedge clk_sys_in);
         wrt(8'h06, 32'h0);
         repeat (10) @(posedge clk_sys_in);
         for (k = 0; k < 4; k = k + 1) begin
            rd(8'h07 + k[7:0], v);
            chk("cnt_hi", v & 32'hFFFF0000, 32'h0);
            chk("cnt_same", 32'(v === c0[k]), same[k]);
            c0[k] = v;
         end
      end
   endtask
   task results;
      begin
         $display("checked %0d err_count %0d", checked, err_count);
         if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask

   initial begin
      repeat (40000) @(posedge clk_sys_in);
      err_count = err_count + 1;
      results;
   end

   initial begin
      for (k = 0; k < 4; k = k + 1) c0[k] = 32'hFFFFFFFF;
      repeat (20) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      ckr(8'h06, 32'h0);
      ckr(8'h0C, 32'h00040004);
      ckr(8'h04, 32'h0);
      $display("test reset values done");
      otp(32'h7FFFFFFF);
      ckr(8'h05, 32'h00005FB1);
      chk("secout", {gdo, tap, pjo, all, sect, red, ovr, bfo}, 32'h7FF);
      ckr(8'h03, 32'h005A013A);
      wrt(8'h03, 32'h0);
      ckr(8'h03, 32'h005A013A);
      wrt(8'h05, 32'h00000900);
      chk("sectors", {all, sect, red}, 32'h12);
      wrt(8'h05, 32'h80000020);
      chk("override", {ovr, bfo}, 32'h3);
      wrt(8'h05, 32'h0);
      ckr(8'h05, 32'h80000020);
      otp(32'h0);
      ckr(8'h05, 32'h0);
      ckr(8'h03, 32'h005A003A);
      bt <= 6'h05;
      ckr(8'h03, 32'h005A0005);
      $display("test security done");
      for (k = 0; k < 4; k = k + 1) begin
         wrt(8'h06, 32'hFFFFFFFC | k);
         chk("run", {crun, prun}, k);
         ckr(8'h06, k);
      end
      osc_round(32'h3, 32'h0);
      @(posedge clk_sys_in);
      rst_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      osc_round(32'h0, 32'hF);
      osc_round(32'h1, 32'h3);
      $display("test oscillators done");
      snap(11'h6DF);
      ckr(8'h10, 32'h6DF);
      snap(11'h100);
      ckr(8'h10, 32'h100);
      wrt(8'h10, 32'h0);
      ckr(8'h10, 32'h100);
      wrt(8'h10, 32'hFFFFF6DF);
      ckr(8'h10, 32'h7DF);
      $display("test snapshot done");
      results;
   end
endmodule
